//--- core/pmpu_core.sv
// packed move, pack and state-clear execution unit with fault checks
// Functional notes
// RULE1: state clear writes tag word all ones
// RULE2: other operations write tag word zeros
// RULE3: tag word: eight 2-bit fields, 11 empty
// RULE4: software clears state after packed routines
// RULE5: dword move in zero-extends into register
// RULE6: dword move out writes low 32 bits
// RULE7: dword move only packed with int/memory
// RULE8: qword load copies all 64 bits
// RULE9: qword store copies all 64 bits
// RULE10: qword move never memory to memory
// RULE11: word pack: dest bytes 0-3, source 4-7
// RULE12: word to byte clamps 7F/80
// RULE13: dword pack: dest words 0-1, source 2-3
// RULE14: dword to word clamps 7FFF/8000
// RULE15: packs write packed register; source reg/mem
// RULE16: emulation, task-switched, pending faults everywhere
// RULE17: protected move to unwritable segment faults
// RULE18: protected bad address GP/SS, page fault
// RULE19: protected alignment fault only at level 3
// RULE20: real mode limit check raises interrupt 13
// RULE21: v86 adds page and alignment faults
// RULE22: condition flags never modified
module pmpu_core (
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  input  wire pmpu_pkg::pmpu_req_s i_req,
  input  wire pmpu_pkg::pmpu_ctx_s i_ctx,
  input  wire logic                i_tag_we,
  input  wire logic [15:0]         i_tag_wdata,
  input  wire logic [2:0]          i_reg_rd_idx,
  output logic [15:0]              o_fp_tag_word,
  output pmpu_pkg::pmpu_res_s      o_res,
  output logic [63:0]              o_reg_rd_data,
  output logic [7:0]               o_empty_mask
);
  import pmpu_pkg::*;

  localparam int NREG = 8;

  typedef struct packed {
    logic [15:0]           fp_tag_word;
    logic [NREG-1:0][63:0] packed_reg;
    pmpu_res_s             res;
    logic [63:0]           rd_data;
    logic [7:0]            empty_mask;
  } pmpu_state_s;

  pmpu_state_s state_reg;
  pmpu_state_s state_next;

  function automatic logic [7:0] sat_w2b(input logic [15:0] w);
    logic signed [15:0] s;
    s = $signed(w);
    if (s > 16'sh007F)
      sat_w2b = PMPU_SAT_B_MAX;
    else if (s < -16'sh0080)
      sat_w2b = PMPU_SAT_B_MIN;
    else
      sat_w2b = w[7:0];
  endfunction

  function automatic logic [15:0] sat_d2w(input logic [31:0] d);
    logic signed [31:0] s;
    s = $signed(d);
    if (s > 32'sh00007FFF)
      sat_d2w = PMPU_SAT_W_MAX;
    else if (s < -32'sh00008000)
      sat_d2w = PMPU_SAT_W_MIN;
    else
      sat_d2w = d[15:0];
  endfunction

  logic        is_clear;
  logic        is_move_dword_in;
  logic        is_move_dword_out;
  logic        is_move_qword_ld;
  logic        is_move_qword_st;
  logic        is_pack_wb;
  logic        is_pack_dw;
  logic        known;
  logic        form_ok;
  logic        uses_mem;
  logic        mem_write;
  logic        is_move;
  logic [31:0] mem_end;
  logic [63:0] dst_val;
  logic [63:0] src_val;
  logic [63:0] result;
  pmpu_fault_e fault_kind;

  always_comb
  begin
    is_clear    = i_req.opcode == PMPU_OP_CLEAR;
    is_move_dword_in  = i_req.opcode == PMPU_OP_MOVE_DWORD_IN;
    is_move_dword_out = i_req.opcode == PMPU_OP_MOVE_DWORD_OUT;
    is_move_qword_ld  = i_req.opcode == PMPU_OP_MOVE_QWORD_LD;
    is_move_qword_st  = i_req.opcode == PMPU_OP_MOVE_QWORD_ST;
    is_pack_wb  = i_req.opcode == PMPU_OP_PACK_WB;
    is_pack_dw  = i_req.opcode == PMPU_OP_PACK_DW;
    is_move     = is_move_dword_in | is_move_dword_out | is_move_qword_ld | is_move_qword_st;
    known       = is_clear | is_move | is_pack_wb | is_pack_dw;
    // illegal operand forms are refused as undefined opcodes
    form_ok = 1'b1;
    if (is_move_dword_in)
      form_ok = (i_req.dst_loc == PMPU_LOC_PACKED) && (i_req.src_loc != PMPU_LOC_PACKED); // RULE7
    else if (is_move_dword_out)
      form_ok = (i_req.src_loc == PMPU_LOC_PACKED) && (i_req.dst_loc != PMPU_LOC_PACKED); // RULE7
    else if (is_move_qword_ld)
      form_ok = (i_req.dst_loc == PMPU_LOC_PACKED) && (i_req.src_loc != PMPU_LOC_INT); // RULE10
    else if (is_move_qword_st)
      form_ok = (i_req.src_loc == PMPU_LOC_PACKED) && (i_req.dst_loc != PMPU_LOC_INT); // RULE10
    else if (is_pack_wb | is_pack_dw)
      form_ok = (i_req.dst_loc == PMPU_LOC_PACKED) && (i_req.src_loc != PMPU_LOC_INT); // RULE15
    uses_mem  = !is_clear && ((i_req.src_loc == PMPU_LOC_MEM) || (i_req.dst_loc == PMPU_LOC_MEM));
    mem_write = i_req.dst_loc == PMPU_LOC_MEM;
    mem_end   = i_req.mem_addr + 32'(i_req.mem_size) - 32'h1;

    fault_kind = PMPU_F_NONE;
    if (!known || !form_ok || i_ctx.emulation_bit)
      fault_kind = PMPU_F_UD; // RULE16
    else if (i_ctx.task_switched_bit)
      fault_kind = PMPU_F_NM; // RULE16
    else if (i_ctx.fp_pending)
      fault_kind = PMPU_F_MF; // RULE16
    else if (uses_mem)
    begin
      case (i_ctx.mode)
        PMPU_MODE_PROT:
        begin
          if (is_move && mem_write && i_req.mem_seg_nowrite)
            fault_kind = PMPU_F_GP; // RULE17
          else if (i_req.mem_addr_bad)
            fault_kind = i_req.mem_seg_stack ? PMPU_F_SS : PMPU_F_GP; // RULE18
          else if (i_req.mem_page_fail)
            fault_kind = PMPU_F_PF; // RULE18
          else if (i_req.mem_unaligned && (i_ctx.cpl == PMPU_CPL_USER))
            fault_kind = PMPU_F_AC; // RULE19
        end
        PMPU_MODE_REAL, PMPU_MODE_V86:
        begin
          if ((mem_end < i_req.mem_addr) ||
              (mem_end > (is_move ? PMPU_REAL_LIM_MOV : PMPU_REAL_LIM_PK)))
            fault_kind = PMPU_F_INT13; // RULE20
          else if ((i_ctx.mode == PMPU_MODE_V86) && i_req.mem_page_fail)
            fault_kind = PMPU_F_PF; // RULE21
          else if ((i_ctx.mode == PMPU_MODE_V86) && i_req.mem_unaligned)
            fault_kind = PMPU_F_AC; // RULE21
        end
        default:
          fault_kind = PMPU_F_UD;
      endcase
    end

    dst_val = state_reg.packed_reg[i_req.dst_idx];
    src_val = (i_req.src_loc == PMPU_LOC_PACKED) ? state_reg.packed_reg[i_req.src_idx]
                                                 : i_req.src_data;
    result = 64'h0;
    if (is_move_dword_in)
      result = {32'h0, src_val[31:0]}; // RULE5
    else if (is_move_dword_out)
      result = {32'h0, state_reg.packed_reg[i_req.src_idx][31:0]}; // RULE6
    else if (is_move_qword_ld | is_move_qword_st)
      result = src_val; // RULE8 RULE9
    else if (is_pack_wb)
    begin
      for (int i = 0; i < 4; i++)
      begin
        result[8*i +: 8]      = sat_w2b(dst_val[16*i +: 16]); // RULE11 RULE12
        result[32 + 8*i +: 8] = sat_w2b(src_val[16*i +: 16]); // RULE11 RULE12
      end
    end
    else if (is_pack_dw)
    begin
      for (int i = 0; i < 2; i++)
      begin
        result[16*i +: 16]      = sat_d2w(dst_val[32*i +: 32]); // RULE13 RULE14
        result[32 + 16*i +: 16] = sat_d2w(src_val[32*i +: 32]); // RULE13 RULE14
      end
    end

    state_next = state_reg;
    state_next.res = '0;
    state_next.res.flags_we = 1'b0; // RULE22
    state_next.rd_data = state_reg.packed_reg[i_reg_rd_idx];
    if (i_tag_we)
      state_next.fp_tag_word = i_tag_wdata;
    if (i_req.valid)
    begin
      state_next.res.valid      = 1'b1;
      state_next.res.fault      = fault_kind != PMPU_F_NONE;
      state_next.res.fault_kind = fault_kind;
      state_next.res.err_code   = PMPU_ERR_ZERO;
      state_next.res.vector     = (fault_kind == PMPU_F_INT13) ? PMPU_REAL_VECTOR : 8'h00;
      if (fault_kind == PMPU_F_NONE)
      begin
        // the instruction beats a same-cycle software tag write
        state_next.fp_tag_word = is_clear ? PMPU_TAG_EMPTY : PMPU_TAG_VALID; // RULE1 RULE2
        state_next.res.data = result;
        if (!is_clear && (i_req.dst_loc == PMPU_LOC_PACKED))
        begin
          state_next.res.wr_packed     = 1'b1; // RULE15
          state_next.res.wr_packed_idx = i_req.dst_idx;
          state_next.packed_reg[i_req.dst_idx] = result;
        end
        if (!is_clear && (i_req.dst_loc != PMPU_LOC_PACKED))
        begin
          state_next.res.wr_out     = 1'b1;
          state_next.res.wr_out_loc = i_req.dst_loc;
        end
      end
    end
    for (int r = 0; r < NREG; r++)
      state_next.empty_mask[r] = state_next.fp_tag_word[2*r +: 2] == PMPU_TAG_CODE_EMP; // RULE3
  end

  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state_reg             <= '0;
      state_reg.fp_tag_word <= PMPU_TAG_RESET;
      state_reg.empty_mask  <= 8'hFF;
    end
    else
      state_reg <= state_next;
  end

  assign o_fp_tag_word = state_reg.fp_tag_word;
  assign o_res         = state_reg.res;
  assign o_reg_rd_data = state_reg.rd_data;
  assign o_empty_mask  = state_reg.empty_mask;

  a_clear_tag_empty: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && is_clear && fault_kind == PMPU_F_NONE) |=> o_fp_tag_word == PMPU_TAG_EMPTY) // RULE1
    else $error("tag word not empty after state clear");

  a_other_tag_valid: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && known && !is_clear && fault_kind == PMPU_F_NONE)
    |=> (o_fp_tag_word == PMPU_TAG_VALID && o_empty_mask == 8'h00)) // RULE2
    else $error("tag word not valid after packed operation");

  a_move_dword_zero_ext: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && is_move_dword_in && fault_kind == PMPU_F_NONE)
    |=> (o_res.wr_packed && o_res.data[63:32] == 32'h0 && o_res.data[31:0] == $past(src_val[31:0]))) // RULE5
    else $error("dword move in not zero extended");

  a_move_dword_bad_form: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && (is_move_dword_in || is_move_dword_out) && i_req.dst_loc == i_req.src_loc)
    |=> (o_res.fault && o_res.fault_kind == PMPU_F_UD && !o_res.wr_packed && !o_res.wr_out)) // RULE7
    else $error("illegal dword move form accepted");

  a_move_qword_no_m2m: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && (is_move_qword_ld || is_move_qword_st) && i_req.src_loc == PMPU_LOC_MEM
     && i_req.dst_loc == PMPU_LOC_MEM) |=> o_res.fault) // RULE10
    else $error("memory to memory qword move accepted");

  a_pack_wb_sat: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && is_pack_wb && fault_kind == PMPU_F_NONE && $signed(dst_val[15:0]) > 16'sd127)
    |=> o_res.data[7:0] == PMPU_SAT_B_MAX) // RULE12
    else $error("word to byte overflow not clamped");

  a_pack_dw_sat: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && is_pack_dw && fault_kind == PMPU_F_NONE && $signed(src_val[63:32]) < -32'sd32768)
    |=> o_res.data[63:48] == PMPU_SAT_W_MIN) // RULE14
    else $error("dword to word underflow not clamped");

  a_emu_ud: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (i_req.valid && i_ctx.emulation_bit)
    |=> (o_res.fault_kind == PMPU_F_UD && !o_res.wr_packed && !o_res.wr_out)) // RULE16
    else $error("emulation bit did not raise undefined opcode fault");

  a_ac_cpl: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_res.fault_kind == PMPU_F_AC) |-> $past(i_ctx.mode) != PMPU_MODE_PROT
      || $past(i_ctx.cpl) == PMPU_CPL_USER) // RULE19
    else $error("alignment fault below privilege level 3");

  a_real_int13: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    (o_res.fault_kind == PMPU_F_INT13)
    |-> (o_res.vector == PMPU_REAL_VECTOR && $past(i_ctx.mode) != PMPU_MODE_PROT)) // RULE20
    else $error("interrupt 13 raised wrongly");

  a_flags_kept: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
    o_res.valid |-> !o_res.flags_we) // RULE22
    else $error("condition flags touched");
endmodule

//--- include/pmpu_pkg.sv
// package for the packed move and pack unit: opcodes, faults, structs
package pmpu_pkg;
  localparam logic [7:0]  PMPU_OP_CLEAR     = 8'h77;
  localparam logic [7:0]  PMPU_OP_MOVE_DWORD_IN   = 8'h6E;
  localparam logic [7:0]  PMPU_OP_MOVE_DWORD_OUT  = 8'h7E;
  localparam logic [7:0]  PMPU_OP_MOVE_QWORD_LD   = 8'h6F;
  localparam logic [7:0]  PMPU_OP_MOVE_QWORD_ST   = 8'h7F;
  localparam logic [7:0]  PMPU_OP_PACK_WB   = 8'h63;
  localparam logic [7:0]  PMPU_OP_PACK_DW   = 8'h6B;
  localparam logic [15:0] PMPU_TAG_EMPTY    = 16'hFFFF;
  localparam logic [15:0] PMPU_TAG_VALID    = 16'h0000;
  localparam logic [15:0] PMPU_TAG_RESET    = 16'hFFFF;
  localparam logic [1:0]  PMPU_TAG_CODE_EMP = 2'h3;
  localparam logic [7:0]  PMPU_SAT_B_MAX    = 8'h7F;
  localparam logic [7:0]  PMPU_SAT_B_MIN    = 8'h80;
  localparam logic [15:0] PMPU_SAT_W_MAX    = 16'h7FFF;
  localparam logic [15:0] PMPU_SAT_W_MIN    = 16'h8000;
  localparam logic [31:0] PMPU_REAL_LIM_MOV = 32'h000FFFFF;
  localparam logic [31:0] PMPU_REAL_LIM_PK  = 32'h0000FFFF;
  localparam logic [1:0]  PMPU_CPL_USER     = 2'h3;
  localparam logic [7:0]  PMPU_REAL_VECTOR  = 8'h0D;
  localparam logic [15:0] PMPU_ERR_ZERO     = 16'h0000;

  typedef enum logic [1:0] {
    PMPU_MODE_REAL = 2'b00,
    PMPU_MODE_PROT = 2'b01,
    PMPU_MODE_V86  = 2'b10
  } pmpu_mode_e;

  typedef enum logic [1:0] {
    PMPU_LOC_PACKED = 2'b00,
    PMPU_LOC_INT    = 2'b01,
    PMPU_LOC_MEM    = 2'b10
  } pmpu_loc_e;

  typedef enum logic [3:0] {
    PMPU_F_NONE  = 4'h0,
    PMPU_F_UD    = 4'h1,
    PMPU_F_NM    = 4'h2,
    PMPU_F_MF    = 4'h3,
    PMPU_F_GP    = 4'h4,
    PMPU_F_SS    = 4'h5,
    PMPU_F_PF    = 4'h6,
    PMPU_F_AC    = 4'h7,
    PMPU_F_INT13 = 4'h8
  } pmpu_fault_e;

  // one request from decode and the memory pipeline
  typedef struct packed {
    logic       valid;
    logic [7:0] opcode;
    pmpu_loc_e  dst_loc;
    pmpu_loc_e  src_loc;
    logic [2:0] dst_idx;
    logic [2:0] src_idx;
    logic [63:0] src_data;
    logic [31:0] mem_addr;
    logic [3:0] mem_size;
    logic       mem_seg_stack;
    logic       mem_seg_nowrite;
    logic       mem_addr_bad;
    logic       mem_page_fail;
    logic       mem_unaligned;
  } pmpu_req_s;

  // processor state that steers fault checks
  typedef struct packed {
    pmpu_mode_e mode;
    logic [1:0] cpl;
    logic       emulation_bit;
    logic       task_switched_bit;
    logic       fp_pending;
  } pmpu_ctx_s;

  typedef struct packed {
    logic        valid;
    logic        fault;
    pmpu_fault_e fault_kind;
    logic [15:0] err_code;
    logic [7:0]  vector;
    logic        wr_packed;
    logic [2:0]  wr_packed_idx;
    logic        wr_out;
    pmpu_loc_e   wr_out_loc;
    logic [63:0] data;
    logic        flags_we;
  } pmpu_res_s;
endpackage

//--- tb/pmpu_decoder_model.sv
// decode and memory pipeline model: forwards one request, keeps the last stored memory word
module pmpu_decoder_model (
  input  wire logic                i_ref_clk,
  input  wire logic                i_sys_rst,
  input  wire pmpu_pkg::pmpu_req_s i_cmd,
  input  wire logic                i_go,
  input  wire pmpu_pkg::pmpu_res_s i_res,
  output pmpu_pkg::pmpu_req_s      o_req,
  output logic [63:0]              o_mem_word
);
  timeunit 1ns;
  timeprecision 1ps;
  import pmpu_pkg::*;

  // idle cycles carry scrambled operands so stale data never looks like a request
  always_comb
  begin
    o_req          = i_cmd;
    o_req.src_data = ~i_cmd.src_data;
    o_req.mem_addr = ~i_cmd.mem_addr;
    o_req.valid    = 1'h0;
    if (i_go)
      o_req = i_cmd;
  end

  // only unfaulted memory destinations reach memory
  always_ff @(posedge i_ref_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_mem_word <= 64'h0;
    else if (i_res.valid && !i_res.fault && i_res.wr_out && i_res.wr_out_loc == PMPU_LOC_MEM)
      o_mem_word <= i_res.data;
  end
endmodule

//--- tb/pmpu_core_test.sv
// self-checking bench for the packed move and pack unit
module pmpu_core_test;
  timeunit 1ns;
  timeprecision 1ps;
  import pmpu_pkg::*;

  localparam pmpu_loc_e  LP   = PMPU_LOC_PACKED;
  localparam pmpu_loc_e  LI   = PMPU_LOC_INT;
  localparam pmpu_loc_e  LM   = PMPU_LOC_MEM;
  localparam pmpu_mode_e MR   = PMPU_MODE_REAL;
  localparam pmpu_mode_e MP   = PMPU_MODE_PROT;
  localparam pmpu_mode_e MV   = PMPU_MODE_V86;
  localparam pmpu_ctx_s  CTX0 = '{MP, 2'h0, 1'h0, 1'h0, 1'h0};
  logic        i_ref_clk;
  logic        i_sys_rst;
  pmpu_req_s   cmd;
  pmpu_req_s   req;
  logic        go;
  pmpu_ctx_s   ctx;
  pmpu_ctx_s   nctx;
  logic        tag_we;
  logic [15:0] tag_wdata;
  logic [2:0]  rd_idx;
  logic [15:0] tag;
  pmpu_res_s   o_res;
  pmpu_res_s   res;
  logic [63:0] rd_data;
  logic [63:0] mem_word;
  logic [7:0]  empty_mask;
  int          failures;
  int          n_compared;

  pmpu_decoder_model pmpu_decoder_model_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
    .i_cmd(cmd), .i_go(go), .i_res(o_res), .o_req(req), .o_mem_word(mem_word));
  pmpu_core pmpu_core_inst (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_req(req),
    .i_ctx(ctx), .i_tag_we(tag_we), .i_tag_wdata(tag_wdata), .i_reg_rd_idx(rd_idx),
    .o_fp_tag_word(tag), .o_res(o_res), .o_reg_rd_data(rd_data), .o_empty_mask(empty_mask));

  initial
  begin
    i_ref_clk = 1'h0;
    forever #25 i_ref_clk = ~i_ref_clk;
  end

  task automatic conclude;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
    n_compared++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one request per call; the answer is registered on the taking edge and read 1 ns later
  task automatic op(input logic [7:0] oc, input pmpu_loc_e d, input pmpu_loc_e s,
                    input logic [2:0] di, input logic [2:0] si, input logic [63:0] dat,
                    input logic [31:0] a, input logic [3:0] sz, input logic [4:0] f);
    @(posedge i_ref_clk);
    cmd <= '{1'h1, oc, d, s, di, si, dat, a, sz, f[4], f[3], f[2], f[1], f[0]};
    ctx <= nctx;
    go  <= 1'h1;
    @(posedge i_ref_clk);
    go  <= 1'h0;
    #1;
    res = o_res;
    chk("res_valid", 64'h1, 64'(res.valid));
    chk("flags_we", 64'h0, 64'(res.flags_we));
  endtask

  task automatic rd(input logic [2:0] i, input logic [63:0] exp);
    @(posedge i_ref_clk);
    rd_idx <= i;
    @(posedge i_ref_clk);
    #1;
    chk("reg_rd_data", exp, rd_data);
  endtask

  task automatic flt(input logic [7:0] oc, input pmpu_loc_e d, input pmpu_loc_e s,
                     input pmpu_mode_e m, input logic [1:0] cpl, input logic [2:0] e,
                     input logic [31:0] a, input logic [3:0] sz, input logic [4:0] f,
                     input pmpu_fault_e k);
    nctx = '{m, cpl, e[2], e[1], e[0]};
    op(oc, d, s, 3'h7, 3'h0, 64'h0, a, sz, f);
    nctx = CTX0;
    chk("fault_kind", 64'(k), 64'(res.fault_kind));
    chk("fault", 64'(k != PMPU_F_NONE), 64'(res.fault));
    chk("err_code", 64'h0, 64'(res.err_code));
    chk("vector", (k == PMPU_F_INT13) ? 64'h0D : 64'h0, 64'(res.vector));
    if (k != PMPU_F_NONE)
      chk("wr_packed", 64'h0, 64'(res.wr_packed));
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (5000) @(posedge i_ref_clk);
    failures++;
    conclude();
  end

  initial
  begin
    i_sys_rst = 1'h1;
    cmd = '0;
    go = 1'h0;
    ctx = CTX0;
    nctx = CTX0;
    tag_we = 1'h0;
    tag_wdata = 16'h0;
    rd_idx = 3'h0;
    failures = 0;
    n_compared = 0;
    repeat (10) @(posedge i_ref_clk);
    i_sys_rst <= 1'h0;
    #1;
    chk("tag_word", 64'hFFFF, 64'(tag));
    chk("empty_mask", 64'hFF, 64'(empty_mask));
    $display("test reset done");
    op(PMPU_OP_MOVE_DWORD_IN, LP, LI, 3'h1, 3'h0, 64'hAAAA_BBBB_1234_5678, 32'h0, 4'h4, 5'h0);
    chk("wr_packed_idx", 64'h1, 64'(res.wr_packed_idx));
    chk("tag_word", 64'h0, 64'(tag));
    chk("empty_mask", 64'h0, 64'(empty_mask));
    rd(3'h1, 64'h0000_0000_1234_5678);
    op(PMPU_OP_MOVE_QWORD_LD, LP, LM, 3'h3, 3'h0, 64'hFFF0_FF00_0100_0005, 32'h0, 4'h8, 5'h0);
    rd(3'h3, 64'hFFF0_FF00_0100_0005);
    op(PMPU_OP_PACK_WB, LP, LM, 3'h3, 3'h0, 64'h007F_FF80_8000_7FFF, 32'h8, 4'h8, 5'h0);
    rd(3'h3, 64'h7F80_807F_F080_7F05);
    op(PMPU_OP_MOVE_QWORD_LD, LP, LM, 3'h4, 3'h0, 64'hFFFF_8000_0001_0000, 32'h0, 4'h8, 5'h0);
    op(PMPU_OP_MOVE_QWORD_LD, LP, LM, 3'h6, 3'h0, 64'h0000_1234_FFFE_0000, 32'h0, 4'h8, 5'h0);
    op(PMPU_OP_MOVE_QWORD_ST, LP, LP, 3'h5, 3'h6, 64'h0, 32'h0, 4'h8, 5'h0);
    op(PMPU_OP_PACK_DW, LP, LP, 3'h4, 3'h5, 64'h0, 32'h0, 4'h8, 5'h0);
    rd(3'h4, 64'h1234_8000_8000_7FFF);
    op(PMPU_OP_MOVE_QWORD_ST, LM, LP, 3'h0, 3'h3, 64'h0, 32'h10, 4'h8, 5'h0);
    chk("store_data", 64'h7F80_807F_F080_7F05, res.data);
    chk("wr_out_loc", 64'(LM), 64'(res.wr_out_loc));
    op(PMPU_OP_MOVE_DWORD_OUT, LI, LP, 3'h0, 3'h1, 64'h0, 32'h0, 4'h4, 5'h0);
    chk("dword_out", 64'h1234_5678, 64'(res.data[31:0]));
    chk("wr_out", 64'h1, 64'(res.wr_out));
    chk("wr_out_loc", 64'(LI), 64'(res.wr_out_loc));
    chk("wr_packed", 64'h0, 64'(res.wr_packed));
    chk("mem_word", 64'h7F80_807F_F080_7F05, mem_word);
    $display("test moves and packs done");
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MP, 2'h0, 3'h0, 32'h101, 4'h8, 5'h01, PMPU_F_NONE);
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MR, 2'h0, 3'h0, 32'hF_FFF8, 4'h8, 5'h0, PMPU_F_NONE);
    flt(PMPU_OP_PACK_WB, LP, LM, MR, 2'h0, 3'h0, 32'hFFF8, 4'h8, 5'h0, PMPU_F_NONE);
    op(PMPU_OP_CLEAR, LP, LP, 3'h0, 3'h0, 64'h0, 32'h0, 4'h0, 5'h0);
    chk("tag_word", 64'hFFFF, 64'(tag));
    chk("empty_mask", 64'hFF, 64'(empty_mask));
    for (int m = 0; m < 3; m++)
    begin
      flt(PMPU_OP_MOVE_DWORD_IN, LP, LI, pmpu_mode_e'(m), 2'h0, 3'h7, 0, 4'h4, 0, PMPU_F_UD);
      flt(PMPU_OP_MOVE_DWORD_IN, LP, LI, pmpu_mode_e'(m), 2'h0, 3'h3, 0, 4'h4, 0, PMPU_F_NM);
      flt(PMPU_OP_CLEAR, LP, LP, pmpu_mode_e'(m), 2'h0, 3'h1, 0, 4'h0, 0, PMPU_F_MF);
    end
    flt(PMPU_OP_MOVE_DWORD_OUT, LM, LP, MP, 2'h0, 3'h0, 32'h20, 4'h4, 5'h0A, PMPU_F_GP);
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MP, 2'h0, 3'h0, 32'h20, 4'h8, 5'h14, PMPU_F_SS);
    flt(PMPU_OP_PACK_WB, LP, LM, MP, 2'h0, 3'h0, 32'h20, 4'h8, 5'h04, PMPU_F_GP);
    flt(PMPU_OP_PACK_DW, LP, LM, MP, 2'h3, 3'h0, 32'h21, 4'h8, 5'h03, PMPU_F_PF);
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MP, 2'h3, 3'h0, 32'h21, 4'h8, 5'h01, PMPU_F_AC);
    flt(PMPU_OP_MOVE_DWORD_IN, LP, LM, MR, 2'h0, 3'h0, 32'hF_FFFD, 4'h4, 0, PMPU_F_INT13);
    flt(PMPU_OP_PACK_DW, LP, LM, MR, 2'h0, 3'h0, 32'hFFF9, 4'h8, 0, PMPU_F_INT13);
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MV, 2'h0, 3'h0, 32'h20, 4'h8, 5'h02, PMPU_F_PF);
    flt(PMPU_OP_MOVE_QWORD_LD, LP, LM, MV, 2'h0, 3'h0, 32'h21, 4'h8, 5'h01, PMPU_F_AC);
    flt(PMPU_OP_MOVE_DWORD_IN, LP, LP, MP, 2'h0, 3'h0, 0, 4'h4, 0, PMPU_F_UD);
    flt(PMPU_OP_MOVE_DWORD_OUT, LI, LI, MP, 2'h0, 3'h0, 0, 4'h4, 0, PMPU_F_UD);
    flt(PMPU_OP_MOVE_QWORD_ST, LM, LM, MP, 2'h0, 3'h0, 0, 4'h8, 0, PMPU_F_UD);
    flt(PMPU_OP_PACK_WB, LM, LP, MP, 2'h0, 3'h0, 0, 4'h8, 0, PMPU_F_UD);
    chk("tag_word", 64'hFFFF, 64'(tag));
    $display("test faults done");
    @(posedge i_ref_clk);
    tag_we <= 1'h1;
    tag_wdata <= 16'hC3F0;
    @(posedge i_ref_clk);
    tag_we <= 1'h0;
    #1;
    chk("tag_word", 64'hC3F0, 64'(tag));
    chk("empty_mask", 64'h9C, 64'(empty_mask));
    op(PMPU_OP_CLEAR, LP, LP, 3'h0, 3'h0, 64'h0, 32'h0, 4'h0, 5'h0);
    chk("tag_word", 64'hFFFF, 64'(tag));
    $display("test tag word done");
    conclude();
  end
endmodule
